//--- logic/afcc_pkg.sv
// Constants shared by the channel configuration and calibration block
package afcc_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_IRQ_CLEAR = 12'h008;
  localparam logic [11:0] REG_IRQ_ENABLE = 12'h00C;
  localparam logic [11:0] REG_RESULT = 12'h010;
  localparam logic [11:0] REG_CH_BASE = 12'h100;
  localparam logic [11:0] REG_THR_BASE = 12'h200;
  localparam logic [11:0] REG_GAIN_BASE = 12'h300;
  localparam logic [11:0] REG_OFFS_BASE = 12'h340;

  // Control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CH_EN_LSB = 8;

  // Input and gain word
  localparam int W0_POS_IN_LSB = 12;
  localparam int W0_NEG_IN_LSB = 8;
  localparam int W0_GAIN_LSB = 5;
  localparam int W0_HIGH_VOLTAGE_PATH_SELECT_BIT = 4;
  localparam int W0_LV_IN_LSB = 1;
  localparam int W0_TEMP_COMPENSATION_DISABLE_BIT = 0;
  // Rate and filter word
  localparam int W1_PAIR_LSB = 12;
  localparam int W1_THR_LSB = 8;
  localparam int W1_RATE_LSB = 3;
  localparam int W1_SINC_LSB = 0;
  // Delay and chopping word
  localparam int W2_DELAY_LSB = 10;
  localparam int W2_SETTLE_BIT = 9;
  localparam int W2_FRST_BIT = 8;
  localparam int W2_CHOP_BIT = 7;
  // Excitation word
  localparam int W3_TYPE_BIT = 15;
  localparam int W3_POL_BIT = 14;
  localparam int W3_MAG_LSB = 10;
  localparam int W3_EN_BIT = 9;
  localparam int W3_ODET_BIT = 8;
  localparam int W3_CHOP_BIT = 6;
  localparam int W3_PPIN_LSB = 3;
  localparam int W3_NPIN_LSB = 0;

  // Encodings
  localparam logic [3:0] NEG_SEL_SINGLE = 4'h0;
  localparam logic EXC_TYPE_VOLTAGE = 1'b0;
  localparam logic EXC_POL_POSITIVE = 1'b0;
  localparam logic [3:0] EXC_MAG_6V = 4'hD;
  localparam logic [2:0] EXC_PIN_INPUT2 = 3'h2;

  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [23:0] UPPER_THR_RESET = 24'hFFFFFF;
  localparam logic [23:0] LOWER_THR_RESET = 24'h000000;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam int GAIN_FRAC_BITS = 22;

  // Code limits
  localparam logic [23:0] DIFF_MAX_CODE = 24'hFFFFFF;
  localparam logic [23:0] SE_MAX_CODE = 24'h7FFFFF;
  localparam logic [23:0] SE_MIN_CODE = 24'h800000;

  // Calibration storage
  localparam int NUM_PAIRS = 16;
  localparam logic [5:0] NVM_WORDS = 6'h20;

  // Interrupt status layout
  localparam int STAT_LOAD_DONE_BIT = 0;
  localparam int STAT_CH_LSB = 1;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_STEP_NS = 1000;
  localparam int SETTLE_STEP_CYC = (SETTLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/afcc_top.sv
// Channel configuration, calibration, range alarms and AXI4-Lite register file
// Functional notes
// - Saturation alarm when converter hits maximum code.
// - Saturation alarm only for differential channels.
// - Range alarms compare result against two thresholds.
// - Threshold registers accept any code.
// - Sixteen gain and sixteen offset coefficient registers.
// - Factory coefficients copied from NVM after reset.
// - Coefficient registers writable by software.
// - Correct results with selected gain and offset.
// - Factory pairs 0-7 follow ascending amplifier gains.
// - Any channel may select any pair.
// - Pair pointer sits in word two top nibble.
// - Word one holds inputs, gain, path, compensation.
// - Word two holds pointer, threshold set, rate, filter.
// - Word three holds delay, settling, filter reset, chop.
// - Word four holds excitation source settings.
// - Excitation encodings: voltage, positive, 6 V, input2.
// - Reading time is settle delay plus conversion.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module afcc_top
  import afcc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_THR = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic factory_cal_present,
  output logic nvm_rd,
  output logic [4:0] nvm_addr,
  input wire logic [23:0] nvm_data,
  input wire logic nvm_valid,
  output logic [3:0] conv_channel,
  output logic conv_start,
  output logic [15:0] conv_input_cfg,
  output logic [15:0] conv_rate_cfg,
  output logic [15:0] conv_delay_cfg,
  output logic [15:0] conv_excitation_cfg,
  output logic exc_voltage_mode,
  output logic exc_positive,
  output logic exc_6v,
  output logic exc_to_input2p,
  input wire logic raw_valid,
  input wire logic [23:0] raw_code,
  output logic result_valid,
  output logic [23:0] result_code,
  output logic [3:0] result_channel,
  output logic saturation_alarm,
  output logic above_window_flag,
  output logic below_window_flag,
  output logic irq
);

  localparam int STAT_W = STAT_CH_LSB + 3 * NUM_CH;

  // Refuse sizes the status word and channel index cannot hold
  if (NUM_CH < 1 || NUM_CH > 8 || NUM_THR < 1 || NUM_THR > 8) begin : g_bad_size
    $error("afcc_top: NUM_CH and NUM_THR must be 1 to 8");
  end

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SETTLE,
    SEQ_CONVERT
  } afcc_seq_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic run;
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0][3:0][15:0] cfg;
    logic [NUM_THR-1:0][23:0] upper;
    logic [NUM_THR-1:0][23:0] lower;
    logic [NUM_PAIRS-1:0][23:0] gain;
    logic [NUM_PAIRS-1:0][23:0] offs;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] irq_en;
    logic irq;
    logic loading;
    logic [5:0] nvm_idx;
    logic nvm_rd;
    logic [4:0] nvm_addr;
    afcc_seq_t seq;
    logic [3:0] ch;
    logic [13:0] wait_cnt;
    logic conv_start;
    logic [3:0][15:0] act_cfg;
    logic [3:0] exc;
    logic result_valid;
    logic [23:0] result_code;
    logic [3:0] result_ch;
    logic [2:0] flags;
  } afcc_state_t;

  afcc_state_t s;
  afcc_state_t next_s;

  // Correction and alarm evaluation of the incoming code
  logic ev;
  logic ev_sat;
  logic ev_above;
  logic ev_below;
  logic [23:0] corr;
  logic [STAT_W-1:0] stat_set;

  // Merge a bus write into an existing word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Active channel fields; index kept in range by the sequencer
  logic [15:0] w0;
  logic [15:0] w1;
  logic [3:0] pair;
  logic [2:0] thr_sel;
  logic differential;

  always_comb begin
    logic signed [25:0] ext;
    logic signed [25:0] diff;
    logic signed [50:0] prod;
    logic signed [50:0] scaled;
    ext = '0;
    diff = '0;
    prod = '0;
    scaled = '0;
    // Four-bit modulus so that a count of eight does not wrap to zero
    w0 = s.cfg[3'({1'b0, s.ch[2:0]} % 4'(NUM_CH))][0];
    w1 = s.cfg[3'({1'b0, s.ch[2:0]} % 4'(NUM_CH))][1];
    pair = w1[W1_PAIR_LSB +: 4];
    thr_sel = 3'({1'b0, w1[W1_THR_LSB +: 3]} % 4'(NUM_THR));
    differential = w0[W0_NEG_IN_LSB +: 4] != NEG_SEL_SINGLE;
    ev = (s.seq == SEQ_CONVERT) && raw_valid;
    // Differential codes are unsigned, single-ended codes are two's complement
    if (differential) begin
      ext = {2'b00, raw_code};
    end else begin
      ext = {{2{raw_code[23]}}, raw_code};
    end
    diff = ext - {{2{s.offs[pair][23]}}, s.offs[pair]};
    prod = diff * $signed({1'b0, s.gain[pair]});
    scaled = prod >>> GAIN_FRAC_BITS;
    // Clamp back into the channel's code range instead of wrapping
    if (differential) begin
      if (scaled < 0) begin
        corr = 24'h000000;
      end else if (scaled > $signed({27'h0, DIFF_MAX_CODE})) begin
        corr = DIFF_MAX_CODE;
      end else begin
        corr = scaled[23:0];
      end
    end else begin
      if (scaled > $signed({27'h0, SE_MAX_CODE})) begin
        corr = SE_MAX_CODE;
      end else if (scaled < -$signed({27'h0, 24'h800000})) begin
        corr = SE_MIN_CODE;
      end else begin
        corr = scaled[23:0];
      end
    end
    ev_sat = ev && differential && (raw_code == DIFF_MAX_CODE);
    // Thresholds are free codes; full span needs only the right values
    if (differential) begin
      ev_above = ev && (corr > s.upper[thr_sel]);
      ev_below = ev && (corr < s.lower[thr_sel]);
    end else begin
      ev_above = ev && ($signed(corr) > $signed(s.upper[thr_sel]));
      ev_below = ev && ($signed(corr) < $signed(s.lower[thr_sel]));
    end
  end

  // Sticky event bits: load done, then three per channel
  assign stat_set[STAT_LOAD_DONE_BIT] = s.loading && !next_s.loading;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_stat
    assign stat_set[STAT_CH_LSB + 3*c +: 3] =
        {ev_below, ev_above, ev_sat} & {3{s.ch == 4'(c)}};
  end

  // Next-state logic: bus, loader, sequencer, interrupts
  always_comb begin
    logic [31:0] wd;
    logic [31:0] rd;
    logic rd_ok;
    logic wr_ok;
    logic [3:0] nxt;
    logic found;
    logic [STAT_W-1:0] clr;
    logic [11:0] wa;
    logic [11:0] ra;
    wd = '0;
    rd = '0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    nxt = '0;
    found = 1'b0;
    clr = '0;
    wa = s.awaddr;
    ra = s_axi_araddr;
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.result_valid = 1'b0;
    next_s.flags = 3'b000;

    // Address and data captured independently, in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid) begin
      wr_ok = (wa[1:0] == 2'b00);
      // Misaligned writes are refused and change nothing
      if (wa[1:0] != 2'b00) begin
        wr_ok = 1'b0;
      end else if (wa == REG_CTRL) begin
        wd = merge({16'h0, 8'(s.ch_en), 7'h0, s.run}, s.wdata, s.wstrb);
        next_s.run = wd[CTRL_RUN_BIT];
        next_s.ch_en = wd[CTRL_CH_EN_LSB +: NUM_CH];
      end else if (wa == REG_IRQ_CLEAR) begin
        clr = s.wdata[STAT_W-1:0] & {STAT_W{s.wstrb != 4'h0}};
      end else if (wa == REG_IRQ_ENABLE) begin
        wd = merge(32'(s.irq_en), s.wdata, s.wstrb);
        next_s.irq_en = wd[STAT_W-1:0];
      end else if (wa[11:8] == REG_CH_BASE[11:8] && wa[7:4] < 4'(NUM_CH)) begin
        wd = merge({16'h0, s.cfg[wa[6:4]][wa[3:2]]}, s.wdata, s.wstrb);
        next_s.cfg[wa[6:4]][wa[3:2]] = wd[15:0];
      end else if (wa[11:6] == REG_THR_BASE[11:6] && {1'b0, wa[5:3]} < 4'(NUM_THR)) begin
        if (wa[2]) begin
          wd = merge({8'h0, s.lower[wa[5:3]]}, s.wdata, s.wstrb);
          next_s.lower[wa[5:3]] = wd[23:0];
        end else begin
          wd = merge({8'h0, s.upper[wa[5:3]]}, s.wdata, s.wstrb);
          next_s.upper[wa[5:3]] = wd[23:0];
        end
      end else if (wa[11:6] == REG_GAIN_BASE[11:6]) begin
        wd = merge({8'h0, s.gain[wa[5:2]]}, s.wdata, s.wstrb);
        next_s.gain[wa[5:2]] = wd[23:0];
      end else if (wa[11:6] == REG_OFFS_BASE[11:6]) begin
        wd = merge({8'h0, s.offs[wa[5:2]]}, s.wdata, s.wstrb);
        next_s.offs[wa[5:2]] = wd[23:0];
      end else if (wa != REG_STATUS && wa != REG_RESULT) begin
        wr_ok = 1'b0;
      end
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;

    // Read decode; unmapped addresses answer SLVERR with zero data
    if (s_axi_arvalid && s.arready) begin
      rd_ok = (ra[1:0] == 2'b00);
      if (ra == REG_CTRL) begin
        rd = {16'h0, 8'(s.ch_en), 7'h0, s.run};
      end else if (ra == REG_STATUS) begin
        rd = 32'(s.status);
      end else if (ra == REG_IRQ_CLEAR) begin
        rd = 32'h00000000;
      end else if (ra == REG_IRQ_ENABLE) begin
        rd = 32'(s.irq_en);
      end else if (ra == REG_RESULT) begin
        rd = {4'h0, s.result_ch, s.result_code};
      end else if (ra[11:8] == REG_CH_BASE[11:8] && ra[7:4] < 4'(NUM_CH)) begin
        rd = {16'h0, s.cfg[ra[6:4]][ra[3:2]]};
      end else if (ra[11:6] == REG_THR_BASE[11:6] && {1'b0, ra[5:3]} < 4'(NUM_THR)) begin
        rd = {8'h0, ra[2] ? s.lower[ra[5:3]] : s.upper[ra[5:3]]};
      end else if (ra[11:6] == REG_GAIN_BASE[11:6]) begin
        rd = {8'h0, s.gain[ra[5:2]]};
      end else if (ra[11:6] == REG_OFFS_BASE[11:6]) begin
        rd = {8'h0, s.offs[ra[5:2]]};
      end else begin
        rd_ok = 1'b0;
      end
      next_s.rvalid = 1'b1;
      next_s.arready = 1'b0;
      next_s.rdata = rd_ok ? rd : 32'h00000000;
      next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Factory preload: words 0-15 gains, 16-31 offsets, pair order as stored
    if (s.loading) begin
      if (!factory_cal_present) begin
        next_s.loading = 1'b0;
        next_s.nvm_rd = 1'b0;
      end else if (s.nvm_rd && nvm_valid) begin
        if (s.nvm_idx[4]) begin
          next_s.offs[s.nvm_idx[3:0]] = nvm_data;
        end else begin
          next_s.gain[s.nvm_idx[3:0]] = nvm_data;
        end
        next_s.nvm_idx = s.nvm_idx + 6'h01;
        next_s.nvm_addr = 5'(s.nvm_idx + 6'h01);
        if (s.nvm_idx + 6'h01 == NVM_WORDS) begin
          next_s.loading = 1'b0;
          next_s.nvm_rd = 1'b0;
        end
      end else begin
        next_s.nvm_rd = 1'b1;
      end
    end

    // Next enabled channel after the current one, round robin
    for (int i = 1; i <= NUM_CH; i++) begin
      if (!found && s.ch_en[(int'(s.ch) + i) % NUM_CH]) begin
        found = 1'b1;
        nxt = 4'((int'(s.ch) + i) % NUM_CH);
      end
    end

    // Sequencer: settle delay, then one conversion at the channel's rate
    case (s.seq)
      SEQ_IDLE: begin
        if (s.run && !s.loading && found) begin
          next_s.ch = nxt;
          next_s.act_cfg = s.cfg[nxt[2:0]];
          next_s.wait_cnt = 14'(s.cfg[nxt[2:0]][2][W2_DELAY_LSB +: 6] * SETTLE_STEP_CYC);
          next_s.exc[3] = s.cfg[nxt[2:0]][3][W3_TYPE_BIT] == EXC_TYPE_VOLTAGE;
          next_s.exc[2] = s.cfg[nxt[2:0]][3][W3_POL_BIT] == EXC_POL_POSITIVE;
          next_s.exc[1] = s.cfg[nxt[2:0]][3][W3_MAG_LSB +: 4] == EXC_MAG_6V;
          next_s.exc[0] = s.cfg[nxt[2:0]][3][W3_PPIN_LSB +: 3] == EXC_PIN_INPUT2;
          next_s.seq = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        if (s.wait_cnt == 14'h0000) begin
          next_s.conv_start = 1'b1;
          next_s.seq = SEQ_CONVERT;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 14'h0001;
        end
      end
      SEQ_CONVERT: begin
        if (raw_valid) begin
          next_s.result_valid = 1'b1;
          next_s.result_code = corr;
          next_s.result_ch = s.ch;
          next_s.flags = {ev_below, ev_above, ev_sat};
          next_s.seq = SEQ_IDLE;
        end
      end
      default: begin
        next_s.seq = SEQ_IDLE;
      end
    endcase

    // Set beats clear in the same cycle
    next_s.status = (s.status & ~clr) | stat_set;
    next_s.irq = |(next_s.status & next_s.irq_en);
  end

  // State register; reset values are constants only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.loading <= 1'b1;
      s.seq <= SEQ_IDLE;
      for (int c = 0; c < NUM_CH; c++) begin
        for (int w = 0; w < 4; w++) begin
          s.cfg[c][w] <= CFG_RESET;
        end
      end
      for (int t = 0; t < NUM_THR; t++) begin
        s.upper[t] <= UPPER_THR_RESET;
        s.lower[t] <= LOWER_THR_RESET;
      end
      for (int p = 0; p < NUM_PAIRS; p++) begin
        s.gain[p] <= GAIN_UNITY;
        s.offs[p] <= OFFSET_RESET;
      end
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign nvm_rd = s.nvm_rd;
  assign nvm_addr = s.nvm_addr;
  assign conv_channel = s.ch;
  assign conv_start = s.conv_start;
  assign conv_input_cfg = s.act_cfg[0];
  assign conv_rate_cfg = s.act_cfg[1];
  assign conv_delay_cfg = s.act_cfg[2];
  assign conv_excitation_cfg = s.act_cfg[3];
  assign exc_voltage_mode = s.exc[3];
  assign exc_positive = s.exc[2];
  assign exc_6v = s.exc[1];
  assign exc_to_input2p = s.exc[0];
  assign result_valid = s.result_valid;
  assign result_code = s.result_code;
  assign result_channel = s.result_ch;
  assign saturation_alarm = s.flags[0];
  assign above_window_flag = s.flags[1];
  assign below_window_flag = s.flags[2];
  assign irq = s.irq;

endmodule // afcc_top

//--- bench/afcc_chk_sva.sv
// Port-level checker for the channel configuration and calibration block
`timescale 1ns/1ns
module afcc_chk
  import afcc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_THR = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic nvm_rd,
  input wire logic [4:0] nvm_addr,
  input wire logic nvm_valid,
  input wire logic [3:0] conv_channel,
  input wire logic conv_start,
  input wire logic [15:0] conv_input_cfg,
  input wire logic [15:0] conv_excitation_cfg,
  input wire logic exc_6v,
  input wire logic exc_to_input2p,
  input wire logic [23:0] raw_code,
  input wire logic result_valid,
  input wire logic [3:0] result_channel,
  input wire logic saturation_alarm,
  input wire logic above_window_flag,
  input wire logic below_window_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Single-ended channels have a zero negative select
  a_sat_diff: assert property (saturation_alarm |-> conv_input_cfg[11:8] != NEG_SEL_SINGLE)
    else $error("saturation on single-ended channel");
  a_sat_max: assert property (result_valid && $past(raw_code) == 24'hFFFFFF &&
    conv_input_cfg[11:8] != NEG_SEL_SINGLE |-> saturation_alarm)
    else $error("full-scale code without saturation");
  a_flag_pulse: assert property ((saturation_alarm || above_window_flag || below_window_flag)
    |-> result_valid)
    else $error("flag without result");
  a_result_chan: assert property (result_valid |-> result_channel == conv_channel)
    else $error("result channel differs");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_exc_decode: assert property ($stable(conv_excitation_cfg) |->
    exc_6v == (conv_excitation_cfg[13:10] == EXC_MAG_6V) &&
    exc_to_input2p == (conv_excitation_cfg[5:3] == EXC_PIN_INPUT2))
    else $error("excitation decode wrong");
  a_nvm_hold: assert property (nvm_rd && !nvm_valid |=> nvm_rd && $stable(nvm_addr))
    else $error("memory request dropped");
  a_nvm_step: assert property (nvm_rd && nvm_valid && nvm_addr != 5'h1F |=>
    nvm_rd && nvm_addr == $past(nvm_addr) + 5'h01)
    else $error("memory address not advanced");
  a_nvm_last: assert property (nvm_rd && nvm_valid && nvm_addr == 5'h1F |=> !nvm_rd)
    else $error("load runs past last word");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer not held");
  // Main scenarios
  c_sat: cover property (saturation_alarm);
  c_below: cover property (below_window_flag);
  c_load: cover property (nvm_rd && nvm_valid && nvm_addr == 5'h1F);
endmodule // afcc_chk

bind afcc_top afcc_chk #(.NUM_CH(NUM_CH), .NUM_THR(NUM_THR)) afcc_chk_inst (.*);

//--- bench/afcc_far.sv
// Far-side model: factory coefficient memory and converter front end
`timescale 1ns/1ns
module afcc_far
  import afcc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic nvm_rd,
  input wire logic [4:0] nvm_addr,
  output logic [23:0] nvm_data,
  output logic nvm_valid,
  input wire logic conv_start,
  input wire logic [23:0] code_in,
  output logic raw_valid,
  output logic [23:0] raw_code
);
  logic [1:0] wait_cnt;
  // Memory stalls every word; idle data is inverted so stale values never pass
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_valid <= 1'b0;
      nvm_data <= 24'h000000;
      raw_valid <= 1'b0;
      raw_code <= 24'h000000;
      wait_cnt <= 2'h0;
    end else begin
      nvm_valid <= nvm_rd && !nvm_valid;
      if (nvm_rd && !nvm_valid) begin
        nvm_data <= nvm_addr[4] ? {20'h0, nvm_addr[3:0]} : GAIN_UNITY | {20'h0, nvm_addr[3:0]};
      end else begin
        nvm_data <= ~nvm_data;
      end
      // Converter answers three cycles after the start pulse
      wait_cnt <= conv_start ? 2'h2 : (wait_cnt != 2'h0 ? wait_cnt - 2'h1 : 2'h0);
      raw_valid <= wait_cnt == 2'h1;
      raw_code <= (wait_cnt == 2'h1) ? code_in : ~raw_code;
    end
  end
endmodule // afcc_far

//--- bench/testbench.sv
// Register-level bench for the channel configuration and calibration block
`timescale 1ns/1ns
module testbench;
  import afcc_pkg::*;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nvm_rd;
  logic factory_cal_present, nvm_valid, conv_start, exc_voltage_mode, exc_positive, exc_6v;
  logic exc_to_input2p, raw_valid, result_valid, saturation_alarm, irq;
  logic above_window_flag, below_window_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb, conv_channel, result_channel;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic [4:0] nvm_addr;
  logic [23:0] nvm_data, raw_code, result_code, code_in;
  logic [15:0] conv_input_cfg, conv_rate_cfg, conv_delay_cfg, conv_excitation_cfg;
  int bad_count, n_checks, gap, first;
  logic [31:0] res_seen;

  afcc_top afcc_top_inst (.*);
  afcc_far afcc_far_inst (.*);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) bad_count++;
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_data = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) bad_count++;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_data, e);
  endtask

  // Run channel 1 until two results land, then stop so status settles
  task automatic conv(input logic [15:0] w0, input logic [23:0] code);
    int k;
    int n;
    code_in <= code;
    wr(REG_CH_BASE + 12'h010, {16'h0, w0});
    wr(REG_CTRL, 32'h0000_0201);
    k = 0;
    for (n = 0; n < 3000 && k < 2; n++) begin
      @(posedge clk);
      if (result_valid === 1'b1) begin
        k++;
        gap = n - first;
        first = n;
        res_seen = {1'b0, below_window_flag, above_window_flag, saturation_alarm,
                    result_channel, result_code};
      end
    end
    if (k < 2) bad_count++;
    // Delay code 1, then choose, start, three-cycle converter model, result
    chk(gap, SETTLE_STEP_CYC + 6);
    wr(REG_CTRL, 32'h0);
    // A conversion already under way still lands; wait it out
    repeat (SETTLE_STEP_CYC + 20) @(posedge clk);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    bad_count++;
    test_done;
  end

  initial begin : main
    int i;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    code_in = 24'h0;
    factory_cal_present = 1'b1;
    bad_count = 0;
    n_checks = 0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // Wait for the factory load to finish
    for (i = 0; i < 200; i++) begin
      rd(REG_STATUS);
      if (rd_data[0] === 1'b1) break;
    end
    chk(rd_data, 32'h1);
    rc(REG_GAIN_BASE + 12'h00C, 32'h0040_0003);
    rc(REG_OFFS_BASE + 12'h014, 32'h5);
    rc(REG_THR_BASE, {8'h0, UPPER_THR_RESET});
    rc(REG_CH_BASE + 12'h020, {16'h0, CFG_RESET});
    // Custom pair 9: gain 2.0, offset 16
    wr(REG_GAIN_BASE + 12'h024, 32'h0080_0000);
    wr(REG_OFFS_BASE + 12'h024, 32'h10);
    rc(REG_GAIN_BASE + 12'h024, 32'h0080_0000);
    rc(REG_OFFS_BASE + 12'h024, 32'h10);
    wr(12'hFF0, 32'h0);
    chk(br, RESP_SLVERR);
    rd(12'hFF0);
    chk(rr, RESP_SLVERR);
    wr(REG_CH_BASE + 12'h014, 32'h90A1);
    wr(REG_CH_BASE + 12'h018, 32'h0680);
    wr(REG_CH_BASE + 12'h01C, 32'h3410);
    rc(REG_CH_BASE + 12'h014, 32'h90A1);
    rc(REG_CH_BASE + 12'h018, 32'h0680);
    conv(16'h11F1, 24'h100010);
    chk(res_seen, 32'h0120_0000);
    rc(REG_RESULT, {8'h01, 24'h200000});
    chk(conv_channel, 4'h1);
    chk(conv_delay_cfg, 16'h0680);
    chk(conv_input_cfg, 16'h11F1);
    chk(conv_rate_cfg, 16'h90A1);
    chk(conv_excitation_cfg, 16'h3410);
    chk({exc_voltage_mode, exc_positive, exc_6v, exc_to_input2p}, 4'hF);
    rc(REG_STATUS, 32'h1);
    // Narrow window, saturating differential code
    wr(REG_THR_BASE, 32'h30_0000);
    rc(REG_THR_BASE, 32'h30_0000);
    // Set 1 holds the middle half of the single-ended span
    wr(REG_THR_BASE + 12'h008, 32'h3F_FFFF);
    wr(REG_THR_BASE + 12'h00C, 32'hBF_FFFF);
    rc(REG_THR_BASE + 12'h00C, 32'hBF_FFFF);
    wr(REG_IRQ_ENABLE, 32'h10);
    conv(16'h11F1, 24'hFFFFFF);
    chk(res_seen, 32'h31FF_FFFF);
    rc(REG_RESULT, {8'h01, 24'hFFFFFF});
    rc(REG_STATUS, 32'h31);
    chk(irq, 1'b1);
    wr(REG_IRQ_CLEAR, 32'h30);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // Same code single-ended: signed, no saturation
    conv(16'h10F1, 24'hFFFFFF);
    chk(res_seen, 32'h41FF_FFDE);
    rc(REG_RESULT, {8'h01, 24'hFFFFDE});
    rc(REG_STATUS, 32'h41);
    chk(irq, 1'b0);
    test_done;
  end
endmodule // testbench
